// ---- hdl/ffp_prims.sv ----
// Purpose: Synchronous models of the storage primitive set.
// Assumes: All primitive pins come from outside and are synchronised first.
// Notes: Direct set and clear act on the state at a system clock edge after synchronising, without the primitive clock.
// Function
// - J-K sets on set only, clears on clear only, holds on neither.
// - J-K captures on rising clock edge, output updates on falling edge.
// - J-K with both inputs true inverts output at falling edge.
// - Toggle reverses outputs each time its input becomes true.
// - Inverted-input toggle changes state on the input's falling transition.
// - Latch output follows data while its clock is true.
// - Latch holds data present when its clock went false.
// - Delay element samples and updates on the same rising edge.
// - NAND gate flip-flop sets when either low set input is false.
// - NAND gate flip-flop clears when either low clear input is false.
// - NOR gate flip-flop sets or clears on a true level.
// - Each complement output is always the inverse of its true output.
// - Direct set and clear force state regardless of the primitive clock.
`timescale 1ns/10ps
module ffp_prims
  import ffp_pkg::*;
(
  // System clock and reset.
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // J-K element pins.
  input wire logic jk_set_i,
  input wire logic jk_clr_i,
  input wire logic jk_clk_i,
  input wire logic jk_dset_i,
  input wire logic jk_dclr_i,
  output logic jk_q_o,
  output logic jk_qn_o,
  // Toggle element pins, normal and inverted input.
  input wire logic tg_in_i,
  input wire logic tgn_in_i,
  output logic tg_q_o,
  output logic tg_qn_o,
  output logic tgn_q_o,
  output logic tgn_qn_o,
  // Latching element pins.
  input wire logic lt_d_i,
  input wire logic lt_clk_i,
  output logic lt_q_o,
  output logic lt_qn_o,
  // Delay element pins.
  input wire logic dl_d_i,
  input wire logic dl_clk_i,
  input wire logic dl_dset_i,
  input wire logic dl_dclr_i,
  output logic dl_q_o,
  output logic dl_qn_o,
  // NAND gate flip-flop pins, all four inputs active low.
  input wire logic gn_set_a_n_i,
  input wire logic gn_set_b_n_i,
  input wire logic gn_clr_c_n_i,
  input wire logic gn_clr_d_n_i,
  output logic gn_q_o,
  output logic gn_qn_o,
  // NOR gate flip-flop pins, active high.
  input wire logic gr_set_i,
  input wire logic gr_clr_i,
  output logic gr_q_o,
  output logic gr_qn_o
);
  localparam int NSYNC = 19;

  // Function that applies direct set and clear over a computed state.
  function automatic logic force_state(input logic dset, input logic dclr, input logic st);
    logic r;
    r = st;
    if (dclr) begin
      r = 1'b0;
    end
    if (dset) begin
      r = 1'b1;
    end
    return r;
  endfunction

  // Function that flags an edge of the chosen direction.
  function automatic logic edge_seen(input logic now, input logic prev, input logic dir);
    return (dir == EDGE_RISE) ? (now & ~prev) : (~now & prev);
  endfunction

  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] sy;
  // NAND gate pins are inverted before synchronising, so a stage in reset reads as idle.
  // Without this, the reset copies look like low set inputs and set the flop at release.
  assign raw = {jk_set_i, jk_clr_i, jk_clk_i, jk_dset_i, jk_dclr_i, tg_in_i, tgn_in_i,
                lt_d_i, lt_clk_i, dl_d_i, dl_clk_i, dl_dset_i, dl_dclr_i,
                ~gn_set_a_n_i, ~gn_set_b_n_i, ~gn_clr_c_n_i, ~gn_clr_d_n_i,
                gr_set_i, gr_clr_i};

  // Bring every pin into the system clock domain.
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      ffp_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .async_i(raw[gi]),
        .sync_o(sy[gi])
      );
    end
  endgenerate

  logic s_jset, s_jclr, s_jclk, s_jds, s_jdc, s_tg, s_tgn, s_ld, s_lclk;
  logic s_dd, s_dclk, s_dds, s_ddc, s_ga, s_gb, s_gc, s_gd, s_rs, s_rc;
  assign {s_jset, s_jclr, s_jclk, s_jds, s_jdc, s_tg, s_tgn, s_ld, s_lclk,
          s_dd, s_dclk, s_dds, s_ddc, s_ga, s_gb, s_gc, s_gd, s_rs, s_rc} = sy;

  // State registers and their next values.
  logic jclk_prev_r, jclk_prev_nxt;
  logic jin_set_r, jin_set_nxt;
  logic jin_clr_r, jin_clr_nxt;
  logic jq_r, jq_nxt;
  logic tg_prev_r, tg_prev_nxt;
  logic tgn_prev_r, tgn_prev_nxt;
  logic tq_r, tq_nxt;
  logic tnq_r, tnq_nxt;
  logic lq_r, lq_nxt;
  logic dclk_prev_r, dclk_prev_nxt;
  logic dq_r, dq_nxt;
  logic gq_r, gq_nxt;
  logic rq_r, rq_nxt;
  logic [6:0] qn_r, qn_nxt; // Complement flops, one per primitive.
  logic jk_rise, jk_fall, dl_rise, gn_set, gn_clr;

  // Edge detection on synchronised pins.
  // edges vs system clock
  assign jk_rise = edge_seen(s_jclk, jclk_prev_r, EDGE_RISE);
  assign jk_fall = edge_seen(s_jclk, jclk_prev_r, EDGE_FALL);
  assign dl_rise = edge_seen(s_dclk, dclk_prev_r, EDGE_RISE);
  assign gn_set = s_ga | s_gb;
  assign gn_clr = s_gc | s_gd;

  // Next state of every primitive.
  always_comb begin
    jclk_prev_nxt = s_jclk;
    tg_prev_nxt = s_tg;
    tgn_prev_nxt = s_tgn;
    dclk_prev_nxt = s_dclk;
    jin_set_nxt = jin_set_r;
    jin_clr_nxt = jin_clr_r;
    jq_nxt = jq_r;
    if (jk_rise) begin
      jin_set_nxt = s_jset;
      jin_clr_nxt = s_jclr;
    end
    if (jk_fall) begin
      case ({jin_set_r, jin_clr_r})
        2'b10: jq_nxt = 1'b1;
        2'b01: jq_nxt = 1'b0;
        2'b11: jq_nxt = ~jq_r;
        default: jq_nxt = jq_r;
      endcase
    end
    jq_nxt = force_state(s_jds, s_jdc, jq_nxt);
    tq_nxt = edge_seen(s_tg, tg_prev_r, EDGE_RISE) ? ~tq_r : tq_r;
    tnq_nxt = edge_seen(s_tgn, tgn_prev_r, EDGE_FALL) ? ~tnq_r : tnq_r;
    lq_nxt = s_lclk ? s_ld : lq_r;
    dq_nxt = dl_rise ? s_dd : dq_r;
    dq_nxt = force_state(s_dds, s_ddc, dq_nxt);
    // Conflicting gate inputs leave the set side winning, the NAND pair's output.
    gq_nxt = gn_set ? 1'b1 : (gn_clr ? 1'b0 : gq_r);
    rq_nxt = s_rs ? 1'b1 : (s_rc ? 1'b0 : rq_r);
    qn_nxt = ~{jq_nxt, tq_nxt, tnq_nxt, lq_nxt, dq_nxt, gq_nxt, rq_nxt};
  end

  // Register all primitive state.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      jclk_prev_r <= STATE_RST;
      jin_set_r <= STATE_RST;
      jin_clr_r <= STATE_RST;
      jq_r <= STATE_RST;
      tg_prev_r <= STATE_RST;
      tgn_prev_r <= STATE_RST;
      tq_r <= STATE_RST;
      tnq_r <= STATE_RST;
      lq_r <= STATE_RST;
      dclk_prev_r <= STATE_RST;
      dq_r <= STATE_RST;
      gq_r <= STATE_RST;
      rq_r <= STATE_RST;
      qn_r <= {7{~STATE_RST}};
    end else begin
      jclk_prev_r <= jclk_prev_nxt;
      jin_set_r <= jin_set_nxt;
      jin_clr_r <= jin_clr_nxt;
      jq_r <= jq_nxt;
      tg_prev_r <= tg_prev_nxt;
      tgn_prev_r <= tgn_prev_nxt;
      tq_r <= tq_nxt;
      tnq_r <= tnq_nxt;
      lq_r <= lq_nxt;
      dclk_prev_r <= dclk_prev_nxt;
      dq_r <= dq_nxt;
      gq_r <= gq_nxt;
      rq_r <= rq_nxt;
      qn_r <= qn_nxt;
    end
  end

  // Outputs come straight from flops; each complement flop loads the inverse next state.
  // complement outputs
  assign jk_q_o = jq_r;
  assign jk_qn_o = qn_r[6];
  assign tg_q_o = tq_r;
  assign tg_qn_o = qn_r[5];
  assign tgn_q_o = tnq_r;
  assign tgn_qn_o = qn_r[4];
  assign lt_q_o = lq_r;
  assign lt_qn_o = qn_r[3];
  assign dl_q_o = dq_r;
  assign dl_qn_o = qn_r[2];
  assign gn_q_o = gq_r;
  assign gn_qn_o = qn_r[1];
  assign gr_q_o = rq_r;
  assign gr_qn_o = qn_r[0];

  // Checks on the primitive behaviour.
  sequence s_jk_fall_both;
    jk_fall && jin_set_r && jin_clr_r && !s_jds && !s_jdc;
  endsequence

  property p_jk_toggle;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    s_jk_fall_both |=> (jk_q_o != $past(jk_q_o));
  endproperty
  a_jk_toggle: assert property (p_jk_toggle) else $error("jk did not invert");

  property p_jk_hold;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (!jk_fall && !s_jds && !s_jdc) |=> $stable(jk_q_o);
  endproperty
  a_jk_hold: assert property (p_jk_hold) else $error("jk changed off edge");

  property p_jk_set;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (jk_fall && jin_set_r && !jin_clr_r && !s_jdc) |=> jk_q_o;
  endproperty
  a_jk_set: assert property (p_jk_set) else $error("jk did not set");

  property p_jk_dclr;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (s_jdc && !s_jds) |=> !jk_q_o;
  endproperty
  a_jk_dclr: assert property (p_jk_dclr) else $error("jk direct clear lost");

  property p_tg_rise;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (s_tg && !$past(s_tg)) |=> (tg_q_o != $past(tg_q_o));
  endproperty
  a_tg_rise: assert property (p_tg_rise) else $error("toggle missed rise");

  property p_tgn_fall;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (!s_tgn && $past(s_tgn)) |=> (tgn_q_o != $past(tgn_q_o));
  endproperty
  a_tgn_fall: assert property (p_tgn_fall) else $error("inverted toggle missed fall");

  property p_lt_follow;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    s_lclk |=> (lt_q_o == $past(s_ld));
  endproperty
  a_lt_follow: assert property (p_lt_follow) else $error("latch not following");

  property p_lt_hold;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    !s_lclk |=> $stable(lt_q_o);
  endproperty
  a_lt_hold: assert property (p_lt_hold) else $error("latch not holding");

  property p_dl_edge;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (dl_rise && !s_dds && !s_ddc) |=> (dl_q_o == $past(s_dd));
  endproperty
  a_dl_edge: assert property (p_dl_edge) else $error("delay missed sample");

  property p_gn_set;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (s_ga || s_gb) |=> gn_q_o;
  endproperty
  a_gn_set: assert property (p_gn_set) else $error("nand ff not set");

  property p_gn_clr;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (!s_ga && !s_gb && (s_gc || s_gd)) |=> !gn_q_o;
  endproperty
  a_gn_clr: assert property (p_gn_clr) else $error("nand ff not cleared");

  property p_gr_clr;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (s_rc && !s_rs) |=> !gr_q_o;
  endproperty
  a_gr_clr: assert property (p_gr_clr) else $error("nor ff not cleared");

  property p_pin_to_q;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (lt_clk_i && lt_d_i) [*4] |-> lt_q_o;
  endproperty
  a_pin_to_q: assert property (p_pin_to_q) else $error("latch pin path too slow");

  property p_q_compl;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    ({jk_qn_o, tg_qn_o, tgn_qn_o, lt_qn_o, dl_qn_o, gn_qn_o, gr_qn_o}
      == ~{jk_q_o, tg_q_o, tgn_q_o, lt_q_o, dl_q_o, gn_q_o, gr_q_o});
  endproperty
  a_q_compl: assert property (p_q_compl) else $error("complement output mismatch");
endmodule

// ---- hdl/ffp_pkg.sv ----
// Purpose: Shared constants for the storage primitive set.
// Assumes: One system clock, all primitive inputs sampled against it.
// Notes: Edge selections are one-bit constants.
package ffp_pkg;
  // Selects the rising edge of a primitive clock or input.
  localparam logic EDGE_RISE = 1'b1;
  // Selects the falling edge of a primitive clock or input.
  localparam logic EDGE_FALL = 1'b0;
  // Reset value of every true-state bit; complement flops take its inverse.
  localparam logic STATE_RST = 1'b0;
  // Synchroniser reset value.
  localparam logic SYNC_RST = 1'b0;
  // Gate flip-flop polarity choices.
  typedef enum logic {FFP_GATE_NAND, FFP_GATE_NOR} ffp_gate_e;
endpackage

// ---- hdl/ffp_sync.sv ----
// Purpose: Two-stage synchroniser for one bit.
// Assumes: Input may change at any time relative to sys_clk_i.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/10ps
module ffp_sync
  import ffp_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Asynchronous input and its synchronised copy.
  input wire logic async_i,
  output logic sync_o
);
  logic meta_r;
  logic meta_nxt;
  logic sync_r;
  logic sync_nxt;

  // Next values of the two stages.
  always_comb begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  // Register both stages.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_r <= SYNC_RST;
      sync_r <= SYNC_RST;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;
endmodule

// ---- dv/tb_flip_flop_primitive_set.sv ----
// Purpose: Self-checking bench for the storage primitive set.
// Assumes: Outputs settle within three clock edges of an input change.
// Notes: Inputs change on falling edges and are held for four cycles, except in J-K pulses (one to five), the first reset (eight) and short waits (one to three).
`timescale 1ns/10ps
module tb_flip_flop_primitive_set;
  import ffp_pkg::*;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic jk_set_i = 1'b0, jk_clr_i = 1'b0, jk_clk_i = 1'b0, jk_dset_i = 1'b0, jk_dclr_i = 1'b0;
  logic tg_in_i = 1'b0, tgn_in_i = 1'b0, lt_d_i = 1'b0, lt_clk_i = 1'b0;
  logic dl_d_i = 1'b0, dl_clk_i = 1'b0, dl_dset_i = 1'b0, dl_dclr_i = 1'b0;
  logic gn_set_a_n_i = 1'b1, gn_set_b_n_i = 1'b1, gn_clr_c_n_i = 1'b1, gn_clr_d_n_i = 1'b1;
  logic gr_set_i = 1'b0, gr_clr_i = 1'b0;
  logic jk_q_o, jk_qn_o, tg_q_o, tg_qn_o, tgn_q_o, tgn_qn_o, lt_q_o, lt_qn_o;
  logic dl_q_o, dl_qn_o, gn_q_o, gn_qn_o, gr_q_o, gr_qn_o;
  int err_total = 0;
  int n_checks = 0;

  // The primitive set under test.
  ffp_prims i_ffp_prims (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .jk_set_i(jk_set_i),
    .jk_clr_i(jk_clr_i), .jk_clk_i(jk_clk_i), .jk_dset_i(jk_dset_i), .jk_dclr_i(jk_dclr_i),
    .jk_q_o(jk_q_o), .jk_qn_o(jk_qn_o), .tg_in_i(tg_in_i), .tgn_in_i(tgn_in_i),
    .tg_q_o(tg_q_o), .tg_qn_o(tg_qn_o), .tgn_q_o(tgn_q_o), .tgn_qn_o(tgn_qn_o),
    .lt_d_i(lt_d_i), .lt_clk_i(lt_clk_i), .lt_q_o(lt_q_o), .lt_qn_o(lt_qn_o),
    .dl_d_i(dl_d_i), .dl_clk_i(dl_clk_i), .dl_dset_i(dl_dset_i), .dl_dclr_i(dl_dclr_i),
    .dl_q_o(dl_q_o), .dl_qn_o(dl_qn_o), .gn_set_a_n_i(gn_set_a_n_i),
    .gn_set_b_n_i(gn_set_b_n_i), .gn_clr_c_n_i(gn_clr_c_n_i), .gn_clr_d_n_i(gn_clr_d_n_i),
    .gn_q_o(gn_q_o), .gn_qn_o(gn_qn_o), .gr_set_i(gr_set_i), .gr_clr_i(gr_clr_i),
    .gr_q_o(gr_q_o), .gr_qn_o(gr_qn_o));

  // A 50 ns clock for the 20 MHz system domain.
  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // Waits a number of falling edges, where the bench changes inputs.
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  // Compares one value and counts the comparison.
  task automatic check(input string name, input logic seen, input logic exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", name, exp, seen);
    end
  endtask

  // Compares a true output and its complement against one expected state.
  task automatic chkq(input string name, input logic q, input logic qn, input logic exp);
    check(name, q, exp);
    check({name, "_n"}, qn, ~exp);
  endtask

  // Prints the verdict and ends the run.
  task automatic results();
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One full clock pulse of the J-K element; output must wait for the fall.
  task automatic jk_pulse(input logic j, input logic k, input logic q_old, input logic q_new);
    jk_set_i = j;
    jk_clr_i = k;
    wt(2);
    jk_clk_i = 1'b1;
    wt(5);
    chkq("jk_rank", jk_q_o, jk_qn_o, q_old);
    jk_clk_i = 1'b0;
    wt(4);
    chkq("jk_out", jk_q_o, jk_qn_o, q_new);
    jk_set_i = 1'b0;
    jk_clr_i = 1'b0;
    wt(1);
  endtask

  // J-K truth table, then direct set and clear with the clock idle.
  task automatic sc_jk();
    jk_pulse(1'b1, 1'b0, 1'b0, 1'b1);
    jk_pulse(1'b0, 1'b0, 1'b1, 1'b1);
    jk_pulse(1'b0, 1'b1, 1'b1, 1'b0);
    jk_pulse(1'b1, 1'b1, 1'b0, 1'b1);
    jk_pulse(1'b1, 1'b1, 1'b1, 1'b0);
    jk_dset_i = 1'b1;
    wt(4);
    chkq("jk_dset", jk_q_o, jk_qn_o, 1'b1);
    jk_dset_i = 1'b0;
    jk_dclr_i = 1'b1;
    wt(4);
    chkq("jk_dclr", jk_q_o, jk_qn_o, 1'b0);
    jk_dclr_i = 1'b0;
    wt(2);
  endtask

  // Toggles divide by two on rising input, inverted form on falling input.
  task automatic sc_toggle();
    tg_in_i = 1'b1;
    tgn_in_i = 1'b1;
    wt(4);
    chkq("tg_rise1", tg_q_o, tg_qn_o, 1'b1);
    chkq("tgn_rise", tgn_q_o, tgn_qn_o, 1'b0);
    tg_in_i = 1'b0;
    tgn_in_i = 1'b0;
    wt(4);
    chkq("tg_fall", tg_q_o, tg_qn_o, 1'b1);
    chkq("tgn_fall", tgn_q_o, tgn_qn_o, 1'b1);
    tg_in_i = 1'b1;
    wt(4);
    chkq("tg_rise2", tg_q_o, tg_qn_o, 1'b0);
    tg_in_i = 1'b0;
    wt(2);
  endtask

  // Latch follows data while enabled and holds once disabled.
  task automatic sc_latch();
    lt_clk_i = 1'b1;
    lt_d_i = 1'b1;
    wt(4);
    chkq("lt_follow1", lt_q_o, lt_qn_o, 1'b1);
    lt_d_i = 1'b0;
    wt(4);
    chkq("lt_follow0", lt_q_o, lt_qn_o, 1'b0);
    lt_d_i = 1'b1;
    wt(4);
    lt_clk_i = 1'b0;
    wt(4);
    lt_d_i = 1'b0;
    wt(4);
    chkq("lt_hold", lt_q_o, lt_qn_o, 1'b1);
  endtask

  // Delay element updates only on a rising clock edge; direct inputs override.
  task automatic sc_delay();
    dl_d_i = 1'b1;
    wt(4);
    chkq("dl_noedge", dl_q_o, dl_qn_o, 1'b0);
    dl_clk_i = 1'b1;
    wt(4);
    chkq("dl_rise", dl_q_o, dl_qn_o, 1'b1);
    dl_d_i = 1'b0;
    wt(4);
    dl_clk_i = 1'b0;
    wt(4);
    chkq("dl_fall", dl_q_o, dl_qn_o, 1'b1);
    dl_dset_i = 1'b1;
    dl_clk_i = 1'b1;
    wt(4);
    chkq("dl_dset", dl_q_o, dl_qn_o, 1'b1);
    dl_dset_i = 1'b0;
    dl_dclr_i = 1'b1;
    wt(4);
    chkq("dl_dclr", dl_q_o, dl_qn_o, 1'b0);
    dl_dclr_i = 1'b0;
    dl_clk_i = 1'b0;
    wt(2);
  endtask

  // Gate flip-flops; set and clear are never asserted together here.
  task automatic sc_gate();
    gn_set_a_n_i = 1'b0;
    gr_set_i = 1'b1;
    wt(4);
    chkq("gn_set_a", gn_q_o, gn_qn_o, 1'b1);
    chkq("gr_set", gr_q_o, gr_qn_o, 1'b1);
    gn_set_a_n_i = 1'b1;
    gr_set_i = 1'b0;
    wt(4);
    chkq("gr_hold", gr_q_o, gr_qn_o, 1'b1);
    gn_clr_c_n_i = 1'b0;
    gr_clr_i = 1'b1;
    wt(4);
    chkq("gn_clr_c", gn_q_o, gn_qn_o, 1'b0);
    chkq("gr_clr", gr_q_o, gr_qn_o, 1'b0);
    gn_clr_c_n_i = 1'b1;
    gr_clr_i = 1'b0;
    gn_set_b_n_i = 1'b0;
    wt(4);
    chkq("gn_set_b", gn_q_o, gn_qn_o, 1'b1);
    gn_set_b_n_i = 1'b1;
    wt(4);
    gn_clr_d_n_i = 1'b0;
    wt(4);
    chkq("gn_clr_d", gn_q_o, gn_qn_o, 1'b0);
    gn_clr_d_n_i = 1'b1;
    wt(2);
  endtask

  // Every primitive shows the reset state, with no false set from idle pins.
  task automatic sc_rst_chk();
    chkq("rst_jk", jk_q_o, jk_qn_o, STATE_RST);
    chkq("rst_tg", tg_q_o, tg_qn_o, STATE_RST);
    chkq("rst_tgn", tgn_q_o, tgn_qn_o, STATE_RST);
    chkq("rst_lt", lt_q_o, lt_qn_o, STATE_RST);
    chkq("rst_dl", dl_q_o, dl_qn_o, STATE_RST);
    chkq("rst_gn", gn_q_o, gn_qn_o, STATE_RST);
    chkq("rst_gr", gr_q_o, gr_qn_o, STATE_RST);
  endtask

  // Reset in mid-run clears the latch and inverted toggle left set by earlier scenarios.
  task automatic sc_midrst();
    chkq("pre_lt", lt_q_o, lt_qn_o, 1'b1);
    chkq("pre_tgn", tgn_q_o, tgn_qn_o, 1'b1);
    nrst_i = 1'b0;
    wt(1);
    chkq("in_rst_lt", lt_q_o, lt_qn_o, STATE_RST);
    wt(3);
    nrst_i = 1'b1;
    wt(2);
    sc_rst_chk();
  endtask

  // Main sequence: reset, then each primitive in turn, then a second reset.
  initial begin
    repeat (8) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    wt(2);
    sc_rst_chk();
    sc_jk();
    sc_toggle();
    sc_latch();
    sc_delay();
    sc_gate();
    sc_midrst();
    results();
  end
endmodule
